/* File: design/miss_handler_params.svh */
/*
 constants for the L1 miss handler: line geometry, request kinds, limits.
 assumes one core clock and a pipeline that holds a request while stalled.
*/
// Notes on behaviour
// [RULE1] A line filled by a nontemporal prefetch that missed L2 is never written into L2 when evicted.
// [RULE2] A nontemporal prefetch miss still trains the hardware prefetcher and that stream is tagged nontemporal.
// [RULE3] The three hinted prefetches behave exactly like the plain read prefetch and fill the L1 data cache.
// [RULE4] A write-intent prefetch fill installs the line in the modified state.
// [RULE5] Streaming stores may complete weakly ordered against other loads and stores.
// [RULE6] Software places a store fence between streaming and later normal stores, and the fence holds later stores until streaming stores drain.
// [RULE7] Streaming stores bypass the caches and go to memory through write-combining buffers.
// [RULE8] A streaming store never issues a read or line fill for its target line.
// [RULE9] Ordinary writes to write-combining memory regions are combined automatically.
// [RULE10] At most eight outstanding misses are tracked, prefetches included.
// [RULE11] With all miss entries busy, the next read request stalls until one frees, never dropped or reordered.
// [RULE12] Pending prefetches are serviced and returned in issue order.
// [RULE13] The sizes of the L1 and L2 caches are reported through the processor id query.
// [RULE14] Every handled line is 64 bytes long and 64-byte aligned.
// [RULE15] Concurrent requests to the same line share one outstanding-miss entry.
// [RULE16] Each L1 line carries a nontemporal tag bit that decides whether its eviction writes into L2; here fill_no_l2_writeback decides.
`ifndef MISS_HANDLER_PARAMS_SVH
`define MISS_HANDLER_PARAMS_SVH
`define ADDR_W 40
`define LINE_BYTES 64
`define LINE_OFS_W 6
`define MAX_MISSES 8
`define L1_SIZE_KB 16'h0040
`define L2_SIZE_KB 16'h0200
`define KIND_W 4
`endif

/* File: design/miss_handler_pkg.sv */
/*
 request kinds and line states for the L1 miss handler.
 assumes the params header is included by each user.
*/
package miss_handler_pkg;
	typedef enum logic [3:0] {
		req_load,
		req_store,
		req_prefetch,
		req_hint0_prefetch,
		req_hint1_prefetch,
		req_hint2_prefetch,
		req_write_prefetch,
		req_nontemporal_prefetch,
		req_streaming_store,
		req_store_fence
	} req_kind_e;
	typedef enum logic [1:0] {
		line_shared,
		line_exclusive,
		line_modified
	} line_state_e;
endpackage

/* File: design/l1_prefetch_miss_handler.sv */
/*
 L1 data cache miss handler: in-order miss table, fill install attributes,
 eviction writeback filter, streaming store path and store fence hold.
 assumes the pipeline holds req_* stable while req_ready is low, that the
 memory side answers reads in issue order, and that the write-combining
 path accepts a line per wc_ready handshake.
*/
`include "miss_handler_params.svh"
module l1_prefetch_miss_handler
	import miss_handler_pkg::*;
#(
	parameter int MAX_MISSES = `MAX_MISSES,
	parameter int ADDR_W = `ADDR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// request from load/store pipeline
	input wire logic req_valid,
	input wire logic [3:0] req_kind,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic req_wc_region,
	input wire logic req_l2_hit,
	output logic req_ready,
	// memory read request, answered in order
	output logic mem_rd_valid,
	output logic [ADDR_W-1:0] mem_rd_addr,
	input wire logic mem_rd_ready,
	input wire logic mem_rsp_valid,
	// fill into the L1 data cache
	output logic fill_valid,
	output logic [ADDR_W-1:0] fill_addr,
	output logic [1:0] fill_state,
	output logic fill_nontemporal_stream_tag,
	output logic fill_no_l2_writeback,
	// hardware prefetcher training
	output logic train_valid,
	output logic [ADDR_W-1:0] train_addr,
	output logic train_nontemporal,
	// write-combining path to memory
	output logic wc_valid,
	output logic [ADDR_W-1:0] wc_addr,
	input wire logic wc_ready,
	// eviction filter
	input wire logic evict_valid,
	input wire logic evict_dirty,
	input wire logic evict_no_l2_writeback,
	input wire logic [ADDR_W-1:0] evict_addr,
	output logic l2_wb_valid,
	output logic [ADDR_W-1:0] l2_wb_addr,
	// processor id query
	input wire logic id_query,
	output logic [15:0] id_l1_size_kb,
	output logic [15:0] id_l2_size_kb,
	output logic id_valid
);
	localparam int IW = $clog2(MAX_MISSES);
	localparam int LW = ADDR_W - `LINE_OFS_W;

	// miss table as an in-order ring
	logic [LW-1:0] line_reg [MAX_MISSES];
	logic [LW-1:0] line_next [MAX_MISSES];
	logic [MAX_MISSES-1:0] sent_reg, sent_next, busy_reg, busy_next;
	logic [1:0] st_reg [MAX_MISSES];
	logic [1:0] st_next [MAX_MISSES];
	logic [MAX_MISSES-1:0] nt_reg, nt_next, nol2_reg, nol2_next;
	logic [IW-1:0] head_reg, head_next, tail_reg, tail_next, iss_reg;
	logic [IW-1:0] iss_next;
	logic [IW:0] count_reg, count_next;
	logic wc_pend_reg, wc_pend_next;
	logic [ADDR_W-1:0] wc_addr_reg, wc_addr_next;
	// registered outputs
	logic fill_v_n, train_v_n, train_nt_n, l2wb_n, id_v_n, rdy_n;
	logic [ADDR_W-1:0] fill_a_n, train_a_n, l2wb_a_n;
	logic [1:0] fill_s_n;
	logic fill_nt_n, fill_nol2_n;

	logic [LW-1:0] req_line;
	logic [MAX_MISSES-1:0] hit;
	logic is_read, is_nt, is_wpf, is_stream, merge, retire;
	logic rd_v_n;
	logic [ADDR_W-1:0] rd_a_n;
	req_kind_e kind;

	always_comb begin
		kind = req_kind_e'(req_kind);
		req_line = req_addr[ADDR_W-1:`LINE_OFS_W]; // RULE14
		is_nt = (kind == req_nontemporal_prefetch);
		is_wpf = (kind == req_write_prefetch);
		// hinted prefetches fold into the plain read prefetch
		is_read = kind inside {req_load, req_prefetch, req_hint0_prefetch,
			req_hint1_prefetch, req_hint2_prefetch, req_write_prefetch,
			req_nontemporal_prefetch, req_store}; // RULE3
		// wc regions combine ordinary stores like streaming ones
		is_stream = (kind == req_streaming_store)
			|| (kind == req_store && req_wc_region); // RULE7 RULE9
		if (is_stream)
			is_read = 1'b0; // RULE8
		// the entry filling this cycle is gone: merging into it would
		// lose a write-intent upgrade
		retire = mem_rsp_valid && busy_reg[head_reg] && sent_reg[head_reg];
		for (int i = 0; i < MAX_MISSES; i++)
			hit[i] = busy_reg[i] && line_reg[i] == req_line
				&& !(retire && IW'(i) == head_reg); // RULE15
		merge = |hit;
	end

	always_comb begin
		line_next = line_reg;
		st_next = st_reg;
		sent_next = sent_reg;
		busy_next = busy_reg;
		nt_next = nt_reg;
		nol2_next = nol2_reg;
		head_next = head_reg;
		tail_next = tail_reg;
		iss_next = iss_reg;
		count_next = count_reg;
		wc_pend_next = wc_pend_reg;
		wc_addr_next = wc_addr_reg;
		fill_v_n = 1'b0;
		fill_a_n = '0;
		fill_s_n = line_shared;
		fill_nt_n = 1'b0;
		fill_nol2_n = 1'b0;
		train_v_n = 1'b0;
		train_a_n = '0;
		train_nt_n = 1'b0;
		if (wc_pend_reg && wc_ready)
			wc_pend_next = 1'b0;
		// in-order issue of the oldest unsent entry
		if (busy_reg[iss_reg] && !sent_reg[iss_reg] && mem_rd_ready) begin
			sent_next[iss_reg] = 1'b1; // RULE12
			iss_next = iss_reg + 1'b1;
		end
		// fills retire from the head in order
		if (retire) begin
			fill_v_n = 1'b1; // RULE12
			fill_a_n = {line_reg[head_reg], {`LINE_OFS_W{1'b0}}}; // RULE14
			fill_s_n = st_reg[head_reg]; // RULE4
			fill_nt_n = nt_reg[head_reg]; // RULE16
			fill_nol2_n = nol2_reg[head_reg]; // RULE1
			busy_next[head_reg] = 1'b0;
			sent_next[head_reg] = 1'b0;
			head_next = head_reg + 1'b1;
			count_next = count_next - 1'b1;
		end
		// a fence books nothing: ready already waited for the wc line
		if (req_valid && req_ready && kind != req_store_fence) begin
			if (is_stream) begin
				// no ordering against the miss table
				wc_pend_next = 1'b1; // RULE5 RULE7
				wc_addr_next = {req_line, {`LINE_OFS_W{1'b0}}};
			end else if (is_read && merge) begin
				for (int i = 0; i < MAX_MISSES; i++)
					if (hit[i] && is_wpf)
						st_next[i] = line_modified; // RULE4 RULE15
			end else if (is_read && count_reg < (IW+1)'(MAX_MISSES)) begin
				busy_next[tail_reg] = 1'b1; // RULE10
				sent_next[tail_reg] = 1'b0;
				line_next[tail_reg] = req_line;
				st_next[tail_reg] = (is_wpf || kind == req_store) ?
					line_modified : line_exclusive; // RULE4
				nt_next[tail_reg] = is_nt; // RULE16
				nol2_next[tail_reg] = is_nt && !req_l2_hit; // RULE1
				tail_next = tail_reg + 1'b1;
				count_next = count_next + 1'b1;
				// loads, stores and prefetches that allocate train, nontemporal marked
				train_v_n = 1'b1; // RULE2
				train_a_n = {req_line, {`LINE_OFS_W{1'b0}}};
				train_nt_n = is_nt; // RULE2
			end
		end
	end

	// ready is registered and cannot see the next kind, so it promises
	// every resource; reads also wait on a pending wc line as the price
	always_comb begin
		rdy_n = 1'b1;
		// fence holds until streaming stores drain
		if (wc_pend_next)
			rdy_n = 1'b0; // RULE6
		// a full table stalls reads rather than dropping them
		if (count_next == (IW+1)'(MAX_MISSES))
			rdy_n = 1'b0; // RULE11
		// next oldest unsent entry, registered to keep the port a flop
		rd_v_n = busy_next[iss_next] && !sent_next[iss_next];
		rd_a_n = {line_next[iss_next], {`LINE_OFS_W{1'b0}}}; // RULE14
	end

	// eviction writeback filter and id query
	always_comb begin
		l2wb_n = evict_valid && evict_dirty
			&& !evict_no_l2_writeback; // RULE1 RULE16
		l2wb_a_n = {evict_addr[ADDR_W-1:`LINE_OFS_W],
			{`LINE_OFS_W{1'b0}}}; // RULE14
		id_v_n = id_query; // RULE13
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < MAX_MISSES; i++) begin
				line_reg[i] <= '0;
				st_reg[i] <= line_shared;
			end
			sent_reg <= '0;
			busy_reg <= '0;
			nt_reg <= '0;
			nol2_reg <= '0;
			head_reg <= '0;
			tail_reg <= '0;
			iss_reg <= '0;
			count_reg <= '0;
			wc_pend_reg <= 1'b0;
			wc_addr_reg <= '0;
			req_ready <= 1'b0;
			mem_rd_valid <= 1'b0;
			mem_rd_addr <= '0;
			fill_valid <= 1'b0;
			fill_addr <= '0;
			fill_state <= line_shared;
			fill_nontemporal_stream_tag <= 1'b0;
			fill_no_l2_writeback <= 1'b0;
			train_valid <= 1'b0;
			train_addr <= '0;
			train_nontemporal <= 1'b0;
			l2_wb_valid <= 1'b0;
			l2_wb_addr <= '0;
			id_valid <= 1'b0;
			id_l1_size_kb <= '0;
			id_l2_size_kb <= '0;
		end else begin
			line_reg <= line_next;
			st_reg <= st_next;
			sent_reg <= sent_next;
			busy_reg <= busy_next;
			nt_reg <= nt_next;
			nol2_reg <= nol2_next;
			head_reg <= head_next;
			tail_reg <= tail_next;
			iss_reg <= iss_next;
			count_reg <= count_next;
			wc_pend_reg <= wc_pend_next;
			wc_addr_reg <= wc_addr_next;
			req_ready <= rdy_n;
			mem_rd_valid <= rd_v_n;
			mem_rd_addr <= rd_a_n;
			fill_valid <= fill_v_n;
			fill_addr <= fill_a_n;
			fill_state <= fill_s_n;
			fill_nontemporal_stream_tag <= fill_nt_n;
			fill_no_l2_writeback <= fill_nol2_n;
			train_valid <= train_v_n;
			train_addr <= train_a_n;
			train_nontemporal <= train_nt_n;
			l2_wb_valid <= l2wb_n;
			l2_wb_addr <= l2wb_a_n;
			id_valid <= id_v_n;
			id_l1_size_kb <= `L1_SIZE_KB; // RULE13
			id_l2_size_kb <= `L2_SIZE_KB; // RULE13
		end
	end

	// wc outputs are the pending line registers themselves
	assign wc_valid = wc_pend_reg;
	assign wc_addr = wc_addr_reg;
endmodule

/* File: sim/miss_handler_monitor.sv */
/*
 port checker for the miss handler.
 assumes it is bound to every l1_prefetch_miss_handler instance.
*/
`include "miss_handler_params.svh"
module miss_handler_monitor #(
	parameter int MAX_MISSES = 8,
	parameter int ADDR_W = 40
) (
	// grouped to keep the checker short
	input wire logic clk, rstn, req_valid, req_ready,
	input wire logic mem_rd_valid, mem_rd_ready, mem_rsp_valid,
	input wire logic [ADDR_W-1:0] mem_rd_addr, wc_addr, evict_addr,
	input wire logic [ADDR_W-1:0] l2_wb_addr,
	input wire logic fill_valid, wc_valid, wc_ready, l2_wb_valid,
	input wire logic [1:0] fill_state,
	input wire logic evict_valid, evict_dirty, evict_no_l2_writeback,
	input wire logic id_query, id_valid,
	input wire logic [15:0] id_l1_size_kb, id_l2_size_kb
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// reads sent but not answered; response may share a cycle with a send
	logic [4:0] open_reg, open_next;
	always_comb begin
		open_next = open_reg + 5'(mem_rd_valid && mem_rd_ready)
			- 5'(mem_rsp_valid);
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			open_reg <= '0;
		else
			open_reg <= open_next;
	end
	a_miss_cap: assert property (open_reg <= MAX_MISSES)
		else $error("too many reads outstanding");
	a_rd_aligned: assert property (mem_rd_valid |->
		mem_rd_addr[5:0] == 6'h00) else $error("read not line aligned");
	a_rd_held: assert property (mem_rd_valid && !mem_rd_ready |=>
		mem_rd_valid && $stable(mem_rd_addr)) else $error("read dropped");
	a_wc_held: assert property (wc_valid && !wc_ready |=>
		wc_valid && $stable(wc_addr)) else $error("wc line dropped");
	a_wc_aligned: assert property (wc_valid |->
		wc_addr[5:0] == 6'h00) else $error("wc line not aligned");
	a_fill_follows: assert property (mem_rsp_valid |=> fill_valid)
		else $error("answer without fill");
	a_fill_cause: assert property (fill_valid |-> $past(mem_rsp_valid))
		else $error("fill without answer");
	a_wb_pass: assert property (evict_valid && evict_dirty &&
		!evict_no_l2_writeback |=> l2_wb_valid && l2_wb_addr[ADDR_W-1:6]
		== $past(evict_addr[ADDR_W-1:6])) else $error("writeback lost");
	a_wb_block: assert property (evict_valid && evict_no_l2_writeback
		|=> !l2_wb_valid) else $error("suppressed line written back");
	a_id_answer: assert property (id_query |=> id_valid &&
		id_l1_size_kb == `L1_SIZE_KB && id_l2_size_kb == `L2_SIZE_KB)
		else $error("size query wrong");
	c_modified_fill: cover property (fill_valid && fill_state == 2'h2);
	c_wc_send: cover property (wc_valid && wc_ready);
	c_stall: cover property (req_valid && !req_ready);
endmodule
bind l1_prefetch_miss_handler miss_handler_monitor #(
	.MAX_MISSES(MAX_MISSES), .ADDR_W(ADDR_W)) i_mon (.*);

/* File: sim/mem_side_model.sv */
/*
 memory side: random read acceptance, in-order answers, wc acceptance.
 assumes hold and wc_hold come from the bench to freeze answers and wc acceptance.
*/
module mem_side_model (
	input wire logic clk, rstn, mem_rd_valid, wc_valid, hold, wc_hold,
	output logic mem_rd_ready, mem_rsp_valid, wc_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	int pend;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend <= 0;
			mem_rd_ready <= 0;
			mem_rsp_valid <= 0;
			wc_ready <= 0;
		end else begin
			pend <= pend + int'(mem_rd_valid && mem_rd_ready) - int'(mem_rsp_valid);
			mem_rd_ready <= $urandom_range(3) != 0;
			wc_ready <= !wc_hold && $urandom_range(1);
			// oldest read answered first, one pulse each
			mem_rsp_valid <= !hold && pend - int'(mem_rsp_valid) > 0
				&& $urandom_range(2) == 0;
		end
	end
endmodule

/* File: sim/tb.sv */
/*
 self-checking bench for the miss handler.
 assumes mem_side_model answers reads in order.
*/
`include "miss_handler_params.svh"
module tb import miss_handler_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rstn = 0, req_valid = 0, req_wc_region = 0, req_l2_hit = 0;
	logic evict_valid = 0, evict_dirty = 0, evict_no_l2_writeback = 0;
	logic id_query = 0, hold = 0, wc_hold = 0;
	logic [3:0] req_kind = '0;
	logic [39:0] req_addr = '0, evict_addr = '0;
	logic req_ready, mem_rd_valid, mem_rd_ready, mem_rsp_valid, fill_valid;
	logic fill_nontemporal_stream_tag, fill_no_l2_writeback, train_valid;
	logic train_nontemporal, wc_valid, wc_ready, l2_wb_valid, id_valid;
	logic [1:0] fill_state;
	logic [15:0] id_l1_size_kb, id_l2_size_kb;
	logic [39:0] mem_rd_addr, fill_addr, train_addr, wc_addr, l2_wb_addr;
	int err_total = 0, n_compared = 0, n_alloc = 0, n_rd = 0, n_wc = 0;
	int n_wc_exp = 0, cyc = 0;
	logic [39:0] q_addr[$];
	logic [1:0] q_st[$];
	logic q_nt[$], q_nowb[$];
	logic [39:0] q_wc[$], q_rd[$];
	l1_prefetch_miss_handler i_l1_prefetch_miss_handler (.*);
	mem_side_model i_mem_side_model (.*);
	always #25 clk = ~clk;
	task automatic check(string name, logic [63:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s exp %0h seen %0h", name, exp, seen);
		end
	endtask
	task give_verdict;
		$display("mismatches %0d compares %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [1:0] exp_state(logic [3:0] k);
		return (k == req_write_prefetch || k == req_store) ? 2'h2 : 2'h1;
	endfunction
	task put(req_kind_e k, logic [39:0] a, logic w, logic h);
		@(posedge clk);
		req_kind <= k;
		req_addr <= a;
		req_wc_region <= w;
		req_l2_hit <= h;
		req_valid <= 1;
	endtask
	// waits for the taking edge, then books what should follow
	task take;
		int n;
		logic m;
		n = 0;
		m = 0;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 300);
		req_valid <= 0;
		if (n >= 300)
			check("taken", 0, 1);
		if (req_kind == req_streaming_store || req_kind == req_store
			&& req_wc_region) begin
			n_wc_exp++;
			q_wc.push_back({req_addr[39:6], 6'h00});
		end else if (req_kind <= 4'h7) begin
			foreach (q_addr[i])
				if (q_addr[i][39:6] == req_addr[39:6]) begin
					m = 1;
					if (req_kind == req_write_prefetch)
						q_st[i] = 2'h2;
				end
			if (!m) begin
				n_alloc++;
				q_addr.push_back(req_addr);
				q_rd.push_back({req_addr[39:6], 6'h00});
				q_st.push_back(exp_state(req_kind));
				q_nt.push_back(req_kind == req_nontemporal_prefetch);
				q_nowb.push_back(req_kind == req_nontemporal_prefetch
					&& !req_l2_hit);
				#1 check("train", train_valid, 1);
				check("train nt", train_nontemporal, q_nt[$]);
				check("train addr", train_addr[39:6],
					req_addr[39:6]);
			end else
				#1 check("train merge", train_valid, 0);
		end
	endtask
	task drain;
		for (int n = 0; n < 500 && q_addr.size() > 0; n++)
			@(posedge clk);
		repeat (4) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (mem_rd_valid === 1'b1 && mem_rd_ready) begin
			n_rd++;
			if (q_rd.size() == 0)
				check("rd extra", 1, 0);
			else
				check("rd addr", mem_rd_addr, q_rd.pop_front());
		end
		if (wc_valid === 1'b1 && wc_ready) begin
			n_wc++;
			if (q_wc.size() == 0)
				check("wc extra", 1, 0);
			else
				check("wc addr", wc_addr, q_wc.pop_front());
		end
		if (fill_valid === 1'b1 && q_addr.size() == 0)
			check("fill extra", 1, 0);
		else if (fill_valid === 1'b1) begin
			check("fill addr", fill_addr, {q_addr[0][39:6], 6'h00});
			check("fill state", fill_state, q_st[0]);
			check("fill tag", fill_nontemporal_stream_tag, q_nt[0]);
			check("fill nowb", fill_no_l2_writeback, q_nowb[0]);
			void'(q_addr.pop_front());
			void'(q_st.pop_front());
			void'(q_nt.pop_front());
			void'(q_nowb.pop_front());
		end
		if (cyc > 20000) begin
			err_total++;
			give_verdict;
		end
	end
	initial begin
		void'($urandom(48));
		repeat (8) @(posedge clk);
		rstn <= 1;
		repeat (2) @(posedge clk);
		id_query <= 1;
		@(posedge clk) id_query <= 0;
		#1 check("id valid", id_valid, 1);
		check("l1 size", id_l1_size_kb, `L1_SIZE_KB);
		check("l2 size", id_l2_size_kb, `L2_SIZE_KB);
		for (int j = 0; j < 4; j++) begin
			@(posedge clk);
			{evict_dirty, evict_no_l2_writeback} <= 2'(j);
			evict_addr <= 40'({$urandom, $urandom});
			evict_valid <= 1;
			@(posedge clk) evict_valid <= 0;
			#1 check("wb", l2_wb_valid, j == 2);
			check("wb addr", l2_wb_addr[39:6] & {34{j == 2}},
				evict_addr[39:6] & {34{j == 2}});
		end
		// every read kind, plus streaming and wc-region stores
		for (int i = 0; i < 48; i++) begin
			put(req_kind_e'(i % 8), {22'($urandom), 12'(i), 6'($urandom)}, 0,
				1'($urandom_range(1)));
			take;
			if (i % 6 == 0 || i % 6 == 3) begin
				put(i % 6 ? req_store : req_streaming_store,
					{28'($urandom), 12'h400 + 12'(i)}, i % 6 != 0, 0);
				take;
			end
		end
		drain;
		// full table: ninth read must wait, then all return in order
		hold <= 1;
		for (int j = 0; j < 9; j++) begin
			put(req_hint1_prefetch, {28'h0, 6'(j), 6'h00} + 40'h800000, 0, 0);
			if (j == 8) begin
				repeat (4) @(posedge clk);
				check("stall", req_ready, 0);
				hold <= 0;
			end
			take;
		end
		drain;
		// three requests to one line share one entry
		hold <= 1;
		put(req_prefetch, 40'h900040, 0, 0);
		take;
		put(req_write_prefetch, 40'h900065, 0, 0);
		take;
		put(req_hint0_prefetch, 40'h900070, 0, 0);
		take;
		hold <= 0;
		drain;
		// fence held back behind an unsent streaming store
		wc_hold <= 1;
		put(req_streaming_store, 40'hA00000, 0, 0);
		take;
		put(req_store_fence, 40'h0, 0, 0);
		repeat (4) @(posedge clk);
		check("fence held", req_ready, 0);
		wc_hold <= 0;
		take;
		drain;
		check("reads", n_rd, n_alloc);
		check("wc lines", n_wc, n_wc_exp);
		give_verdict;
	end
endmodule
